// ### rtl/hpb_device.sv
// device end: host port, packet memory, transmit slots and receive ring
//
// Operation
// R1 - answer only while chip select active, polarity settable
// R2 - port select 0 index, 1 data
// R3 - data port reaches register named by index
// R4 - host writes index before data access
// R5 - first memory command after address is dummy load
// R6 - address steps by bus width, prefetches next
// R7 - host discards data of dummy access
// R8 - 16K memory: 3K transmit, 13K receive
// R9 - write wraps to 0 at 3K when enabled
// R10 - read wraps to 0C00h at 16K when enabled
// R11 - two transmit slots used alternately
// R12 - control selects CRC/pad; slot status registers
// R13 - reset: start address 0, first slot
// R14 - host loads data, length, then start bit
// R15 - second length only after first send ends
// R16 - each finished packet toggles the slot
// R17 - receive ring starts at 0C00h after reset
// R18 - header 01h, status, length low, high
// R19 - packets start word aligned in 16-bit mode
// R20 - low byte on low data lines
`timescale 1ns/1ps
`include "hpb_cfg.svh"
module hpb_device (
	input  wire logic        mclk,
	input  wire logic        rst,
	hpb_if.dev               pins,
	input  wire logic        cs_invert,
	input  wire logic        bus16,
	input  wire logic        tx_done,
	input  wire logic [7:0]  tx_stat,
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_end,
	input  wire logic [7:0]  rx_stat,
	output logic             tx_go,
	output logic [13:0]      tx_addr,
	output logic [15:0]      tx_len,
	output logic [1:0]       tx_mode,
	output logic             rx_ready
);
	logic [7:0]  mem [0:`HPB_MEM_BYTES-1];
	logic [7:0]  index_ff, tx_ctrl_ff, tx_st1_ff, tx_st2_ff, imr_ff, rx_st_ff, hdr_byte, reg_rdata;
	logic [15:0] len_ff, buf_ff, tx_len_ff, sd_ff, rx_cnt_ff, nxt_buf;
	logic [13:0] addr_ff, tx_start_ff, tx_addr_ff, rx_start_ff, rx_ptr_ff;
	logic [13:0] nxt_addr, nxt_addr1, addr1, hdr_addr, nxt_rx_start;
	logic        primed_ff, slot_ff, tx_go_ff, sd_oe_n_ff, rx_ready_ff;
	logic [1:0]  tx_mode_ff, hdr_cnt_ff;
	logic        cs_act, rd, wr, mem_rd, mem_wr;
	hpb_pkg::hpb_rx_state_t rx_state_ff;
	// ====================
	// helpers
	function automatic logic [13:0] ring_inc(input logic [13:0] a);
		ring_inc = (a == `HPB_RX_LAST) ? `HPB_RX_START : a + 14'h0001;
	endfunction

	function automatic logic [13:0] step_addr(input logic [13:0] a, input logic is_wr, input logic wide,
			input logic wrap);
		logic [14:0] n;
		n = {1'b0, a} + (wide ? 15'h0002 : 15'h0001); // [R6]
		if (wrap && is_wr && n >= {1'b0, `HPB_TX_END}) begin
			step_addr = `HPB_TX_START; // [R9]
		end else if (wrap && !is_wr && n[14]) begin
			step_addr = `HPB_RX_START; // [R10]
		end else begin
			step_addr = n[13:0];
		end
	endfunction
	// ====================
	// host port decode
	assign cs_act    = (pins.cs_pin == cs_invert); // [R1]
	assign rd        = cs_act && pins.ior;
	assign wr        = cs_act && pins.iow;
	assign mem_rd    = rd && pins.cmd && (index_ff == `HPB_IX_MEM_RD); // [R3]
	assign mem_wr    = wr && pins.cmd && (index_ff == `HPB_IX_MEM_WR);
	assign nxt_addr  = step_addr(addr_ff, mem_wr, bus16, imr_ff[`HPB_IMR_WRAP]);
	assign nxt_addr1 = nxt_addr + 14'h0001;
	assign addr1     = addr_ff + 14'h0001;
	assign nxt_buf   = primed_ff ? {mem[addr1], mem[addr_ff]} : {mem[nxt_addr1], mem[nxt_addr]}; // [R20]
	assign hdr_addr  = (rx_start_ff > `HPB_RX_LAST - {12'h000, hdr_cnt_ff})
		? rx_start_ff + {12'h000, hdr_cnt_ff} - (`HPB_RX_LAST - `HPB_RX_START + 14'h0001)
		: rx_start_ff + {12'h000, hdr_cnt_ff};
	assign nxt_rx_start = (bus16 && rx_ptr_ff[0]) ? ring_inc(rx_ptr_ff) : rx_ptr_ff; // [R19]

	always_comb begin
		unique case (hdr_cnt_ff)
			2'd0: hdr_byte = `HPB_RX_HDR_MARK; // [R18]
			2'd1: hdr_byte = rx_st_ff;
			2'd2: hdr_byte = rx_cnt_ff[7:0];
			2'd3: hdr_byte = rx_cnt_ff[15:8];
		endcase
	end

	always_comb begin
		unique case (index_ff)
			`HPB_IX_TX_CTRL:  reg_rdata = tx_ctrl_ff;
			`HPB_IX_TX_ST1:   reg_rdata = tx_st1_ff;
			`HPB_IX_TX_ST2:   reg_rdata = tx_st2_ff;
			`HPB_IX_LEN_LO:   reg_rdata = len_ff[7:0];
			`HPB_IX_LEN_HI:   reg_rdata = len_ff[15:8];
			`HPB_IX_IRQ_MASK: reg_rdata = imr_ff;
			`HPB_IX_ADDR_LO:  reg_rdata = addr_ff[7:0];
			`HPB_IX_ADDR_HI:  reg_rdata = {2'b00, addr_ff[13:8]};
			default:          reg_rdata = 8'h00;
		endcase
	end
	// ====================
	// index and plain registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			index_ff <= 8'h00;
			len_ff   <= 16'h0000;
			imr_ff   <= 8'h00;
		end else if (wr && !pins.cmd) begin
			index_ff <= pins.sd[7:0]; // [R2]
		end else if (wr) begin
			if (index_ff == `HPB_IX_LEN_LO) begin
				len_ff[7:0] <= pins.sd[7:0];
			end
			if (index_ff == `HPB_IX_LEN_HI) begin
				len_ff[15:8] <= pins.sd[7:0];
			end
			if (index_ff == `HPB_IX_IRQ_MASK) begin
				imr_ff <= pins.sd[7:0];
			end
		end
	end
	// ====================
	// memory pointer, dummy access and prefetch
	always_ff @(posedge mclk) begin
		if (rst) begin
			addr_ff   <= 14'h0000;
			primed_ff <= 1'b0;
			buf_ff    <= 16'h0000;
		end else if (wr && pins.cmd && index_ff == `HPB_IX_ADDR_LO) begin
			addr_ff[7:0] <= pins.sd[7:0];
			primed_ff    <= 1'b1;
		end else if (wr && pins.cmd && index_ff == `HPB_IX_ADDR_HI) begin
			addr_ff[13:8] <= pins.sd[5:0];
			primed_ff     <= 1'b1;
		end else if (mem_rd || mem_wr) begin
			primed_ff <= 1'b0;
			buf_ff    <= nxt_buf; // [R5] [R6]
			if (!primed_ff) begin
				addr_ff <= nxt_addr; // [R6]
			end
		end
	end
	// ====================
	// packet memory writes from host and receiver
	always_ff @(posedge mclk) begin
		if (mem_wr && !primed_ff) begin
			mem[addr_ff] <= pins.sd[7:0]; // [R8] [R20]
			if (bus16) begin
				mem[addr1] <= pins.sd[15:8];
			end
		end
		if (rx_state_ff != hpb_pkg::HPB_RX_HDR && rx_valid) begin
			mem[rx_ptr_ff] <= rx_data;
		end
		if (rx_state_ff == hpb_pkg::HPB_RX_HDR) begin
			mem[hdr_addr] <= hdr_byte; // [R18]
		end
	end

	// ====================
	// read answer, one cycle after the strobe
	always_ff @(posedge mclk) begin
		if (rst) begin
			sd_ff      <= 16'h0000;
			sd_oe_n_ff <= 1'b1;
		end else begin
			sd_oe_n_ff <= !rd; // [R1]
			if (!pins.cmd) begin
				sd_ff <= {8'h00, index_ff};
			end else if (mem_rd) begin
				sd_ff <= bus16 ? buf_ff : {8'h00, buf_ff[7:0]}; // [R7]
			end else begin
				sd_ff <= {8'h00, reg_rdata};
			end
		end
	end

	// ====================
	// transmit slots
	always_ff @(posedge mclk) begin
		if (rst) begin
			tx_ctrl_ff  <= 8'h00;
			tx_st1_ff   <= 8'h00;
			tx_st2_ff   <= 8'h00;
			slot_ff     <= 1'b0; // [R13]
			tx_start_ff <= `HPB_TX_START; // [R13]
			tx_go_ff    <= 1'b0;
			tx_addr_ff  <= 14'h0000;
			tx_len_ff   <= 16'h0000;
			tx_mode_ff  <= 2'b00;
		end else begin
			tx_go_ff <= 1'b0;
			if (tx_done) begin
				slot_ff              <= !slot_ff; // [R16]
				tx_ctrl_ff[`HPB_TXC_START] <= 1'b0;
				tx_start_ff          <= (tx_start_ff + tx_len_ff[13:0] >= `HPB_TX_END)
					? tx_start_ff + tx_len_ff[13:0] - `HPB_TX_END : tx_start_ff + tx_len_ff[13:0]; // [R11]
				if (slot_ff) begin
					tx_st2_ff <= tx_stat; // [R12]
				end else begin
					tx_st1_ff <= tx_stat; // [R12]
				end
			end
			if (wr && pins.cmd && index_ff == `HPB_IX_TX_CTRL) begin
				tx_ctrl_ff <= pins.sd[7:0];
				if (pins.sd[`HPB_TXC_START]) begin
					tx_go_ff   <= 1'b1; // [R14]
					tx_addr_ff <= tx_start_ff;
					tx_len_ff  <= len_ff;
					tx_mode_ff <= {pins.sd[`HPB_TXC_CRC_OFF], pins.sd[`HPB_TXC_PAD_OFF]}; // [R12]
				end
			end
		end
	end

	// ====================
	// receive ring writer
	always_ff @(posedge mclk) begin
		if (rst) begin
			rx_state_ff <= hpb_pkg::HPB_RX_IDLE;
			rx_start_ff <= `HPB_RX_START; // [R17]
			rx_ptr_ff   <= `HPB_RX_START + `HPB_RX_HDR_BYTES;
			rx_cnt_ff   <= 16'h0000;
			rx_st_ff    <= 8'h00;
			hdr_cnt_ff  <= 2'd0;
			rx_ready_ff <= 1'b0;
		end else begin
			rx_ready_ff <= 1'b1;
			unique case (rx_state_ff)
				hpb_pkg::HPB_RX_IDLE, hpb_pkg::HPB_RX_DATA: begin
					if (rx_valid) begin
						rx_ptr_ff   <= ring_inc(rx_ptr_ff); // [R17]
						rx_cnt_ff   <= rx_cnt_ff + 16'h0001;
						rx_state_ff <= hpb_pkg::HPB_RX_DATA;
					end
					if (rx_end) begin
						rx_st_ff    <= rx_stat;
						rx_state_ff <= hpb_pkg::HPB_RX_HDR;
						rx_ready_ff <= 1'b0;
					end
				end
				hpb_pkg::HPB_RX_HDR: begin
					hdr_cnt_ff  <= hdr_cnt_ff + 2'd1;
					rx_ready_ff <= 1'b0;
					if (hdr_cnt_ff == 2'd3) begin
						rx_state_ff <= hpb_pkg::HPB_RX_IDLE;
						rx_start_ff <= nxt_rx_start; // [R19]
						rx_ptr_ff   <= ring_inc(ring_inc(ring_inc(ring_inc(nxt_rx_start))));
						rx_cnt_ff   <= 16'h0000;
						rx_ready_ff <= 1'b1;
					end
				end
			endcase
		end
	end

	assign pins.dev_sd      = sd_ff;
	assign pins.dev_sd_oe_n = sd_oe_n_ff;
	assign tx_go            = tx_go_ff;
	assign tx_addr          = tx_addr_ff;
	assign tx_len           = tx_len_ff;
	assign tx_mode          = tx_mode_ff;
	assign rx_ready         = rx_ready_ff;
endmodule

// ### rtl/hpb_cfg.svh
// constants of the host port and packet buffer
`ifndef HPB_CFG_SVH
`define HPB_CFG_SVH
`define HPB_MEM_BYTES    16384
`define HPB_TX_END       14'h0c00
`define HPB_RX_START     14'h0c00
`define HPB_RX_LAST      14'h3fff
`define HPB_TX_START     14'h0000
`define HPB_IX_TX_CTRL   8'h02
`define HPB_IX_TX_ST1    8'h03
`define HPB_IX_TX_ST2    8'h04
`define HPB_IX_ADDR_LO   8'hf4
`define HPB_IX_ADDR_HI   8'hf5
`define HPB_IX_MEM_RD    8'hf2
`define HPB_IX_MEM_WR    8'hf8
`define HPB_IX_LEN_LO    8'hfc
`define HPB_IX_LEN_HI    8'hfd
`define HPB_IX_IRQ_MASK  8'hff
`define HPB_TXC_START    1
`define HPB_TXC_PAD_OFF  2
`define HPB_TXC_CRC_OFF  3
`define HPB_IMR_WRAP     7
`define HPB_RX_HDR_MARK  8'h01
`define HPB_RX_HDR_BYTES 14'h0004
`define HPB_HA_CMD       8'h00
`define HPB_HA_STAT      8'h04
`define HPB_HA_RDATA     8'h08
`define HPB_HC_WRITE     16
`define HPB_HC_PORT      17
`endif

// ### rtl/hpb_pkg.sv
// types shared by both ends of the host port
package hpb_pkg;
	typedef enum logic [1:0] {
		HPB_RX_IDLE = 2'b00,
		HPB_RX_DATA = 2'b01,
		HPB_RX_HDR  = 2'b11
	} hpb_rx_state_t;
	typedef enum logic [1:0] {
		HPB_H_IDLE = 2'b00,
		HPB_H_STRB = 2'b01,
		HPB_H_HOLD = 2'b11,
		HPB_H_END  = 2'b10
	} hpb_host_state_t;
endpackage

// ### rtl/hpb_if.sv
// pins between host processor and device host port
`timescale 1ns/1ps
interface hpb_if;
	logic        cs_pin;
	logic        cmd;
	logic        ior;
	logic        iow;
	logic [15:0] host_sd;
	logic        host_sd_oe_n;
	logic [15:0] dev_sd;
	logic        dev_sd_oe_n;
	logic [15:0] sd;
	// resolved level of the shared data lines
	assign sd = !host_sd_oe_n ? host_sd : (!dev_sd_oe_n ? dev_sd : 16'h0000);
	modport host (output cs_pin, output cmd, output ior, output iow, output host_sd, output host_sd_oe_n, input sd);
	modport dev (input cs_pin, input cmd, input ior, input iow, input sd, output dev_sd, output dev_sd_oe_n);
endinterface

// ### rtl/hpb_host.sv
// host end: AHB-Lite command registers driving the host port pins
`timescale 1ns/1ps
`include "hpb_cfg.svh"
module hpb_host (
	input  wire logic        mclk,
	input  wire logic        rst,
	hpb_if.host              pins,
	input  wire logic        cs_invert,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp
);
	hpb_pkg::hpb_host_state_t st_ff;
	logic        dwr_ff;
	logic [7:0]  daddr_ff;
	logic [31:0] hrdata_ff;
	logic [17:0] req_ff;
	logic [15:0] rdata_ff;
	logic        cs_ff;
	logic        cmd_ff;
	logic        ior_ff;
	logic        iow_ff;
	logic [15:0] sd_ff;
	logic        oe_n_ff;
	logic        take;

	// ====================
	// AHB-Lite slave, zero wait states
	assign take = dwr_ff && daddr_ff == `HPB_HA_CMD && st_ff == hpb_pkg::HPB_H_IDLE;

	always_ff @(posedge mclk) begin
		if (rst) begin
			dwr_ff    <= 1'b0;
			daddr_ff  <= 8'h00;
			hrdata_ff <= 32'h0000_0000;
		end else begin
			dwr_ff <= hsel && htrans[1] && hready && hwrite;
			if (hsel && htrans[1] && hready) begin
				daddr_ff <= haddr[7:0];
				unique case (haddr[7:0])
					`HPB_HA_CMD:   hrdata_ff <= {14'h0000, req_ff};
					`HPB_HA_STAT:  hrdata_ff <= {31'h0000_0000, st_ff != hpb_pkg::HPB_H_IDLE};
					`HPB_HA_RDATA: hrdata_ff <= {16'h0000, rdata_ff};
					default:       hrdata_ff <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ====================
	// pin sequencer: strobe, hold, capture, release
	always_ff @(posedge mclk) begin
		if (rst) begin
			st_ff    <= hpb_pkg::HPB_H_IDLE;
			req_ff   <= 18'h0_0000;
			rdata_ff <= 16'h0000;
			cs_ff    <= 1'b0;
			cmd_ff   <= 1'b0;
			ior_ff   <= 1'b0;
			iow_ff   <= 1'b0;
			sd_ff    <= 16'h0000;
			oe_n_ff  <= 1'b1;
		end else begin
			cs_ff <= !cs_invert;
			unique case (st_ff)
				hpb_pkg::HPB_H_IDLE: begin
					if (take) begin
						req_ff  <= hwdata[17:0];
						cs_ff   <= cs_invert;
						cmd_ff  <= hwdata[`HPB_HC_PORT];
						ior_ff  <= !hwdata[`HPB_HC_WRITE];
						iow_ff  <= hwdata[`HPB_HC_WRITE];
						sd_ff   <= hwdata[15:0];
						oe_n_ff <= !hwdata[`HPB_HC_WRITE];
						st_ff   <= hpb_pkg::HPB_H_STRB;
					end
				end
				hpb_pkg::HPB_H_STRB: begin
					cs_ff   <= cs_invert;
					ior_ff  <= 1'b0;
					iow_ff  <= 1'b0;
					oe_n_ff <= 1'b1;
					st_ff   <= hpb_pkg::HPB_H_HOLD;
				end
				hpb_pkg::HPB_H_HOLD: begin
					cs_ff <= cs_invert;
					if (!req_ff[`HPB_HC_WRITE]) begin
						rdata_ff <= pins.sd;
					end
					st_ff <= hpb_pkg::HPB_H_END;
				end
				hpb_pkg::HPB_H_END: begin
					st_ff <= hpb_pkg::HPB_H_IDLE;
				end
			endcase
		end
	end

	assign pins.cs_pin       = cs_ff;
	assign pins.cmd          = cmd_ff;
	assign pins.ior          = ior_ff;
	assign pins.iow          = iow_ff;
	assign pins.host_sd      = sd_ff;
	assign pins.host_sd_oe_n = oe_n_ff;
	assign hrdata            = hrdata_ff;
	assign hreadyout         = 1'b1;
	assign hresp             = 1'b0;
endmodule

// ### verification/hpb_monitor.sv
// checker of the host port pin protocol
`timescale 1ns/1ps
module hpb_monitor (
	input wire logic mclk,
	input wire logic rst,
	input wire logic cs_invert,
	input wire logic cs_pin,
	input wire logic cmd,
	input wire logic ior,
	input wire logic iow,
	input wire logic host_sd_oe_n,
	input wire logic dev_sd_oe_n
);
	logic sel;
	assign sel = cs_pin == cs_invert;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// ========
	// properties
	property p_rd_answer; ior && sel && cmd |=> !dev_sd_oe_n; endproperty
	property p_cs_off; (ior || iow) && !sel |=> dev_sd_oe_n; endproperty
	property p_oe_pulse; !dev_sd_oe_n |=> dev_sd_oe_n; endproperty
	property p_oe_cause; $fell(dev_sd_oe_n) |-> $past(ior) && $past(sel); endproperty
	property p_cs_hold; (ior || iow) |=> $stable(cs_pin) [*2]; endproperty
	property p_spacing; (ior || iow) |=> !(ior || iow) [*3]; endproperty
	property p_no_clash; !host_sd_oe_n |-> dev_sd_oe_n; endproperty
	property p_wr_drive; iow |-> !host_sd_oe_n; endproperty
	property p_rd_release; ior |-> host_sd_oe_n ##1 host_sd_oe_n; endproperty
	// ========
	// assertions
	a_rd_answer: assert property (p_rd_answer)
		else $error("no read answer");
	a_cs_off: assert property (p_cs_off)
		else $error("answer while not selected");
	a_oe_pulse: assert property (p_oe_pulse)
		else $error("device drive too long");
	a_oe_cause: assert property (p_oe_cause)
		else $error("device drive without read");
	a_cs_hold: assert property (p_cs_hold)
		else $error("select not held");
	a_spacing: assert property (p_spacing)
		else $error("strobes too close");
	a_no_clash: assert property (p_no_clash)
		else $error("both ends drive");
	a_wr_drive: assert property (p_wr_drive)
		else $error("write without data");
	a_rd_release: assert property (p_rd_release)
		else $error("host drives during read");
	c_read: cover property (ior && sel && cmd ##1 !dev_sd_oe_n);
	c_write: cover property (iow && sel && cmd);
	c_refused: cover property ((ior || iow) && !sel);
endmodule

// ### verification/hpb_tb_top.sv
// testbench of host port and packet buffer
`timescale 1ns/1ps
`include "hpb_cfg.svh"
module hpb_tb_top;
	logic        mclk, rst, cs_inv_h, cs_inv_d, bus16, tx_done, rx_valid, rx_end, hsel, hwrite;
	logic        hreadyout, hresp, tx_go, rx_ready;
	logic [1:0]  htrans, tx_mode, g_mode;
	logic [7:0]  tx_stat, rx_data, rx_stat;
	logic [13:0] tx_addr, g_addr;
	logic [15:0] tx_len, g_len, q;
	logic [31:0] haddr, hwdata, hrdata, rd;
	int          errors, checks, cycles, gos;
	hpb_if link ();
	hpb_host hpb_host_i (.mclk(mclk), .rst(rst), .pins(link.host), .cs_invert(cs_inv_h), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
	hpb_device hpb_device_i (.mclk(mclk), .rst(rst), .pins(link.dev), .cs_invert(cs_inv_d), .bus16(bus16),
		.tx_done(tx_done), .tx_stat(tx_stat), .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end),
		.rx_stat(rx_stat), .tx_go(tx_go), .tx_addr(tx_addr), .tx_len(tx_len), .tx_mode(tx_mode), .rx_ready(rx_ready));
	hpb_monitor hpb_monitor_i (.mclk(mclk), .rst(rst), .cs_invert(cs_inv_d), .cs_pin(link.cs_pin), .cmd(link.cmd),
		.ior(link.ior), .iow(link.iow), .host_sd_oe_n(link.host_sd_oe_n), .dev_sd_oe_n(link.dev_sd_oe_n));
	always #20 mclk = ~mclk;
	always @(posedge mclk) begin
		cycles++;
		if (tx_go) begin
			gos++;
			g_addr = tx_addr;
			g_len = tx_len;
			g_mode = tx_mode;
		end
		if (cycles == 20000) begin
			errors++;
			end_sim;
		end
	end
	// ========
	// bus tasks
	task end_sim;
		$display("checks=%0d errors=%0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'b10;
		hwrite <= wr;
		@(posedge mclk);
		while (hreadyout !== 1'b1)
			@(posedge mclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge mclk);
		while (hreadyout !== 1'b1)
			@(posedge mclk);
		rd = hrdata;
	endtask
	task pin(input logic port, input logic wr, input logic [15:0] d);
		ahb(1'b1, `HPB_HA_CMD, {14'h0000, port, wr, d});
		rd = 32'h0000_0001;
		while (rd[0] !== 1'b0)
			ahb(1'b0, `HPB_HA_STAT, 32'h0000_0000);
		ahb(1'b0, `HPB_HA_RDATA, 32'h0000_0000);
		q = rd[15:0];
	endtask
	task wreg(input logic [7:0] ix, input logic [7:0] v);
		pin(1'b0, 1'b1, {8'h00, ix});
		pin(1'b1, 1'b1, {8'h00, v});
	endtask
	task rreg(input logic [7:0] ix);
		pin(1'b0, 1'b1, {8'h00, ix});
		pin(1'b1, 1'b0, 16'h0000);
	endtask
	task seek(input logic [13:0] a, input logic [7:0] ix);
		wreg(`HPB_IX_ADDR_LO, a[7:0]);
		wreg(`HPB_IX_ADDR_HI, {2'b00, a[13:8]});
		pin(1'b0, 1'b1, {8'h00, ix});
		pin(1'b1, ix == `HPB_IX_MEM_WR, 16'h0000);
	endtask
	task mrd8(input logic [7:0] exp);
		pin(1'b1, 1'b0, 16'h0000);
		chk({8'h00, q[7:0]}, {8'h00, exp});
	endtask
	// ========
	// scenarios
	task t_cs;
		cs_inv_h <= 1'b1;
		cs_inv_d <= 1'b1;
		wreg(`HPB_IX_LEN_LO, 8'h5a);
		cs_inv_d <= 1'b0;
		wreg(`HPB_IX_LEN_LO, 8'ha5);
		cs_inv_d <= 1'b1;
		rreg(`HPB_IX_LEN_LO);
		chk({8'h00, q[7:0]}, 16'h005a);
		pin(1'b0, 1'b0, 16'h0000);
		chk({8'h00, q[7:0]}, {8'h00, `HPB_IX_LEN_LO});
		cs_inv_h <= 1'b0;
		cs_inv_d <= 1'b0;
	endtask
	task t_mem;
		seek(14'h0010, `HPB_IX_MEM_WR);
		for (int i = 0; i < 4; i++)
			pin(1'b1, 1'b1, {8'h00, 8'ha1 + 8'(i)});
		bus16 <= 1'b1;
		pin(1'b1, 1'b1, 16'hb2b1);
		pin(1'b1, 1'b1, 16'hb4b3);
		bus16 <= 1'b0;
		seek(14'h0010, `HPB_IX_MEM_RD);
		for (int i = 0; i < 4; i++)
			mrd8(8'ha1 + 8'(i));
		for (int i = 0; i < 4; i++)
			mrd8(8'hb1 + 8'(i));
	endtask
	task t_wrap;
		seek(14'h0c00, `HPB_IX_MEM_WR);
		pin(1'b1, 1'b1, 16'h00d0);
		seek(14'h3fff, `HPB_IX_MEM_WR);
		pin(1'b1, 1'b1, 16'h00d1);
		wreg(`HPB_IX_IRQ_MASK, 8'h80);
		seek(14'h0bff, `HPB_IX_MEM_WR);
		pin(1'b1, 1'b1, 16'h00c1);
		pin(1'b1, 1'b1, 16'h00c2);
		seek(14'h3fff, `HPB_IX_MEM_RD);
		mrd8(8'hd1);
		mrd8(8'hd0);
		seek(14'h0bff, `HPB_IX_MEM_RD);
		mrd8(8'hc1);
		mrd8(8'hd0);
		seek(14'h0000, `HPB_IX_MEM_RD);
		mrd8(8'hc2);
		wreg(`HPB_IX_IRQ_MASK, 8'h00);
	endtask
	task t_tx;
		logic [13:0] a;
		a = 14'h0000;
		for (int i = 0; i < 3; i++) begin
			wreg(`HPB_IX_LEN_LO, 8'h40 >> i);
			wreg(`HPB_IX_LEN_HI, 8'h00);
			gos = 0;
			wreg(`HPB_IX_TX_CTRL, {4'h0, 2'(i + 1), 2'b10});
			while (gos == 0)
				@(posedge mclk);
			chk({2'b00, g_addr}, {2'b00, a});
			chk(g_len, {8'h00, 8'h40 >> i});
			chk({14'h0000, g_mode}, {14'h0000, 2'(i + 1)});
			tx_stat <= 8'h50 + 8'(i);
			tx_done <= 1'b1;
			@(posedge mclk);
			tx_done <= 1'b0;
			rreg(i[0] ? `HPB_IX_TX_ST2 : `HPB_IX_TX_ST1);
			chk({8'h00, q[7:0]}, {8'h00, 8'h50 + 8'(i)});
			rreg(`HPB_IX_TX_CTRL);
			chk({8'h00, q[7:0]}, {12'h000, 2'(i + 1), 2'b00});
			a = a + {6'h00, 8'h40 >> i};
		end
	endtask
	task rx_pkt(input logic [7:0] b, input int n, input logic [7:0] st);
		for (int i = 0; i < n; i++) begin
			rx_valid <= 1'b1;
			rx_data <= b + 8'(i);
			@(posedge mclk);
		end
		rx_valid <= 1'b0;
		rx_end <= 1'b1;
		rx_stat <= st;
		@(posedge mclk);
		rx_end <= 1'b0;
		repeat (2)
			@(posedge mclk);
		while (rx_ready !== 1'b1)
			@(posedge mclk);
	endtask
	task t_rx;
		logic [15:0] exp [6];
		exp = '{16'h5a01, 16'h0003, 16'he2e1, 16'h00e3, 16'h5b01, 16'h0001};
		bus16 <= 1'b1;
		rx_pkt(8'he1, 3, 8'h5a);
		rx_pkt(8'hf1, 1, 8'h5b);
		seek(14'h0c00, `HPB_IX_MEM_RD);
		for (int i = 0; i < 6; i++) begin
			pin(1'b1, 1'b0, 16'h0000);
			chk((i == 3) ? {8'h00, q[7:0]} : q, exp[i]);
		end
	endtask
	// ========
	// main sequence
	initial begin
		mclk = 1'b0;
		rst = 1'b1;
		{cs_inv_h, cs_inv_d, bus16, tx_done, rx_valid, rx_end, hsel, hwrite} = 8'h00;
		{tx_stat, rx_data, rx_stat} = 24'h00_0000;
		htrans = 2'b00;
		haddr = 32'h0000_0000;
		hwdata = 32'h0000_0000;
		repeat (20)
			@(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		t_cs;
		t_mem;
		t_wrap;
		t_tx;
		t_rx;
		end_sim;
	end
endmodule
